// [agsc_core.sv]
/*
 * Effective address generation, stack limit check and circular buffer correction.
 * Assumes the decode stage presents one request per cycle with register values already read,
 * and software reaches the registers over Avalon-MM.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1 - exception push places status byte above PC
// RL2 - stack limit bit zero reads zero
// RL3 - stack limit has no reset value
// RL4 - stack pointer addresses compared with limit
// RL5 - push at limit passes, next traps
// RL6 - stack pointer below 0x0800 traps
// RL7 - software avoids stack read after limit write
// RL8 - file register address is 13 bits
// RL9 - file ops default to work register zero
// RL10 - MCU first operand register direct only
// RL11 - pre-modify adds, then uses result
// RL12 - indexed address is pointer plus base
// RL13 - literal offset address is pointer plus literal
// RL14 - move shares one offset register field
// RL15 - X prefetch pointers X, Y pointers Y
// RL16 - software keeps prefetch pointers in space
// RL17 - MAC indexing only on second pointers
// RL18 - branch 16-bit signed, disable 14-bit count
// RL19 - one ring in X, one in Y
// RL20 - power-of-two rings checked both ends
// RL21 - ring bounds from start and end registers
// RL22 - ring length at most 64 Kbytes
// RL23 - Y ring addresses are word aligned
// RL24 - stack post-increments push, pre-decrements pop
// RL25 - X ring needs enable and select not 15
// RL26 - ring checks catch overshoot, not equality
// RL27 - both stack errors form one trap
module agsc_core
    import agsc_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // decode request and answer
    input wire agsc_req_s i_req,
    output agsc_rsp_s o_rsp,
    // trap request
    output logic o_stack_trap
);
    // ************************************************
    // register bus
    // ************************************************
    logic [15:0] stack_limit;
    logic [15:0] x_ring_start;
    logic [15:0] x_ring_end;
    logic [15:0] y_ring_start;
    logic [15:0] y_ring_end;
    logic [15:0] ring_control;
    logic [15:0] trap_count;
    logic bus_done;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ANSWER
    } agsc_bus_e;
    agsc_bus_e bus_state;
    agsc_bus_e next_bus_state;

    wire bus_req = i_avs_read | i_avs_write;
    wire lo_en = i_avs_byteenable[0];
    wire hi_en = i_avs_byteenable[1];
    wire wr_take = i_avs_write & (bus_state == ST_ANSWER);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic lo, input logic hi);
        merge16 = {hi ? wd[15:8] : old[15:8], lo ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // one wait cycle per access: request seen, answered next edge
    always_comb begin
        case (bus_state)
            ST_IDLE: next_bus_state = bus_req ? ST_ANSWER : ST_IDLE;
            ST_ANSWER: next_bus_state = ST_IDLE;
            default: next_bus_state = ST_IDLE;
        endcase
    end
    assign bus_done = (bus_state == ST_ANSWER);
    assign o_avs_waitrequest = bus_req & ~bus_done;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state <= ST_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // limit register keeps no reset value [RL3]
    always_ff @(posedge i_sys_clk) begin
        if (wr_take && i_avs_address == AGSC_OFS_STACK_LIMIT) begin
            stack_limit <= merge16(stack_limit, i_avs_writedata, lo_en, hi_en) & 16'hFFFE; // [RL2]
        end
    end

    // ring bounds [RL21]
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            x_ring_start <= 16'h0000;
            x_ring_end <= 16'h0000;
            y_ring_start <= 16'h0000;
            y_ring_end <= 16'h0000;
            ring_control <= AGSC_RING_CONTROL_RESET;
        end else if (wr_take) begin
            case (i_avs_address)
                AGSC_OFS_X_RING_START: x_ring_start <= merge16(x_ring_start, i_avs_writedata, lo_en, hi_en);
                AGSC_OFS_X_RING_END: x_ring_end <= merge16(x_ring_end, i_avs_writedata, lo_en, hi_en);
                AGSC_OFS_Y_RING_START: y_ring_start <= merge16(y_ring_start, i_avs_writedata, lo_en, hi_en);
                AGSC_OFS_Y_RING_END: y_ring_end <= merge16(y_ring_end, i_avs_writedata, lo_en, hi_en);
                AGSC_OFS_RING_CONTROL: ring_control <= merge16(ring_control, i_avs_writedata, lo_en, hi_en);
                default: ;
            endcase
        end
    end

    wire [15:0] rd_mux =
        (i_avs_address == AGSC_OFS_STACK_LIMIT) ? (stack_limit & 16'hFFFE) : // [RL2]
        (i_avs_address == AGSC_OFS_X_RING_START) ? x_ring_start :
        (i_avs_address == AGSC_OFS_X_RING_END) ? x_ring_end :
        (i_avs_address == AGSC_OFS_Y_RING_START) ? y_ring_start :
        (i_avs_address == AGSC_OFS_Y_RING_END) ? y_ring_end :
        (i_avs_address == AGSC_OFS_RING_CONTROL) ? ring_control :
        (i_avs_address == AGSC_OFS_STATUS) ? trap_count : AGSC_UNMAPPED_READ[15:0];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && bus_state == ST_IDLE) begin
            o_avs_readdata <= {16'h0000, rd_mux};
        end
    end

    // ************************************************
    // request decode
    // ************************************************
    function automatic logic is_x_ptr(input logic [3:0] sel);
        is_x_ptr = (sel == AGSC_X_PTR_A) || (sel == AGSC_X_PTR_B);
    endfunction : is_x_ptr

    function automatic logic is_y_ptr(input logic [3:0] sel);
        is_y_ptr = (sel == AGSC_Y_PTR_A) || (sel == AGSC_Y_PTR_B);
    endfunction : is_y_ptr

    // folds an address that left the ring back inside it
    function automatic logic [15:0] ring_fix(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
        logic [16:0] span;
        span = {1'b0, hi} - {1'b0, lo} + 17'h00002;
        if (v > hi) begin
            ring_fix = v - span[15:0]; // [RL26]
        end else if (v < lo) begin
            ring_fix = v + span[15:0]; // [RL20]
        end else begin
            ring_fix = v;
        end
    endfunction : ring_fix

    // ************************************************
    // address forming
    // ************************************************
    wire req_on = i_req.valid;
    wire sp_access = (i_req.ptr_sel == AGSC_SP_REG); // [RL4]
    wire is_mac = (i_req.cls == AGSC_CLS_MAC);
    wire is_mcu = (i_req.cls == AGSC_CLS_MCU);
    wire [3:0] x_sel = ring_control[AGSC_X_SEL_LSB +: 4];
    wire [3:0] y_sel = ring_control[AGSC_Y_SEL_LSB +: 4];
    wire x_ring_on = ring_control[AGSC_X_ENABLE_BIT] && (x_sel != AGSC_SEL_OFF); // [RL25]
    wire y_ring_on = ring_control[AGSC_Y_ENABLE_BIT] && (y_sel != AGSC_SEL_OFF);
    // one ring per space, never on the stack pointer
    wire x_ring_hit = x_ring_on && (i_req.ptr_sel == x_sel) && !sp_access; // [RL19]
    wire y_ring_hit = y_ring_on && (i_req.ptr_sel == y_sel) && !sp_access && !x_ring_hit;
    wire ring_hit = x_ring_hit | y_ring_hit;
    wire [15:0] ring_lo = x_ring_hit ? x_ring_start : y_ring_start;
    wire [15:0] ring_hi = x_ring_hit ? x_ring_end : y_ring_end;
    wire [16:0] ring_span = {1'b0, ring_hi} - {1'b0, ring_lo} + 17'h00002;
    wire ring_too_long = ring_hit && (ring_span > AGSC_RING_MAX_BYTES); // [RL22]

    wire [15:0] file_ea = {{(16 - AGSC_FILE_ADDR_W){1'b0}}, i_req.file_addr}; // [RL8]
    wire [15:0] step_ea = i_req.ptr_val + i_req.modifier; // [RL11]
    wire [15:0] index_ea = i_req.ptr_val + i_req.base_val; // [RL12] [RL14]
    wire [15:0] lit_ea = i_req.ptr_val + i_req.literal; // [RL13]
    wire [15:0] push_next = i_req.ptr_val + AGSC_WORD_STEP; // [RL24]
    wire [15:0] pop_ea = i_req.ptr_val - AGSC_WORD_STEP; // [RL24]

    logic [15:0] raw_ea;
    logic [15:0] raw_next;
    logic raw_write;
    always_comb begin
        raw_ea = 16'h0000;
        raw_next = i_req.ptr_val;
        raw_write = 1'b0;
        case (i_req.mode)
            AGSC_FILE_DIRECT: begin
                raw_ea = file_ea; // [RL9]
            end
            AGSC_REG_DIRECT: raw_ea = 16'h0000;
            AGSC_INDIRECT: raw_ea = i_req.ptr_val;
            AGSC_POST_MOD: begin
                raw_ea = i_req.ptr_val;
                raw_next = step_ea;
                raw_write = 1'b1;
            end
            AGSC_PRE_MOD: begin
                raw_ea = step_ea;
                raw_next = step_ea;
                raw_write = 1'b1;
            end
            AGSC_REG_INDEXED: raw_ea = index_ea;
            AGSC_LIT_OFFSET: raw_ea = lit_ea;
            AGSC_LITERAL: raw_ea = 16'h0000;
            AGSC_PUSH: begin
                raw_ea = i_req.ptr_val;
                raw_next = push_next;
                raw_write = 1'b1;
            end
            AGSC_POP: begin
                raw_ea = pop_ea;
                raw_next = pop_ea;
                raw_write = 1'b1;
            end
            default: ;
        endcase
    end

    wire ea_is_ptr = (i_req.mode != AGSC_FILE_DIRECT) && (i_req.mode != AGSC_REG_DIRECT)
        && (i_req.mode != AGSC_LITERAL);
    wire [15:0] fixed_ea = ring_fix(raw_ea, ring_lo, ring_hi);
    wire [15:0] fixed_next = ring_fix(raw_next, ring_lo, ring_hi);
    wire [15:0] ring_ea = (ring_hit && ea_is_ptr) ? fixed_ea : raw_ea;
    wire [15:0] ring_next = (ring_hit && raw_write) ? fixed_next : raw_next;
    wire [15:0] final_ea = y_ring_hit ? (ring_ea & 16'hFFFE) : ring_ea; // [RL23]

    // ************************************************
    // stack check
    // ************************************************
    wire over_limit = sp_access && (final_ea > stack_limit); // [RL4] [RL5]
    wire under_floor = sp_access && (final_ea < AGSC_SFR_TOP); // [RL6]
    wire stack_err = req_on && (over_limit || under_floor); // [RL27]

    // ************************************************
    // operand checks and literals
    // ************************************************
    wire mac_bad_ptr = is_mac && !is_x_ptr(i_req.ptr_sel) && !is_y_ptr(i_req.ptr_sel); // [RL15]
    wire mac_bad_index = is_mac && (i_req.mode == AGSC_REG_INDEXED)
        && (i_req.ptr_sel != AGSC_X_PTR_B) && (i_req.ptr_sel != AGSC_Y_PTR_B); // [RL17]
    wire mcu_bad_mode = is_mcu && ((i_req.mode == AGSC_REG_INDEXED) || (i_req.mode == AGSC_LIT_OFFSET)); // [RL10]
    wire req_fault = mac_bad_ptr | mac_bad_index | mcu_bad_mode | ring_too_long;
    wire [15:0] short_lit = {{(16 - AGSC_SHORT_LIT_W){1'b0}}, i_req.literal[AGSC_SHORT_LIT_W - 1:0]}; // [RL10]
    wire [15:0] count_lit = {{(16 - AGSC_DISABLE_LIT_W){1'b0}}, i_req.literal[AGSC_DISABLE_LIT_W - 1:0]}; // [RL18]
    wire [15:0] branch_lit = i_req.literal[AGSC_BRANCH_LIT_W - 1:0]; // [RL18]
    // other class: selector 0 is a branch displacement, else a disable count
    wire [15:0] lit_out = is_mcu ? short_lit :
        (((i_req.cls == AGSC_CLS_OTHER) && (i_req.ptr_sel != 4'h0)) ? count_lit : branch_lit);
    // literal carries the return address word
    wire [23:0] push_word = i_req.exc_push ? {i_req.status_low_byte, i_req.literal} : {8'h00, i_req.literal}; // [RL1]

    // ************************************************
    // answer
    // ************************************************
    agsc_rsp_s next_rsp;
    always_comb begin
        next_rsp = '0;
        next_rsp.valid = req_on;
        next_rsp.addr = final_ea;
        next_rsp.ptr_next = ring_next;
        next_rsp.ptr_write = raw_write;
        next_rsp.in_y_space = is_mac ? is_y_ptr(i_req.ptr_sel) : y_ring_hit; // [RL15]
        next_rsp.literal = lit_out;
        next_rsp.push_word = push_word;
        next_rsp.stack_error = stack_err;
        next_rsp.fault = req_on && req_fault;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rsp <= '0;
            o_stack_trap <= 1'b0;
        end else begin
            o_rsp <= next_rsp;
            o_stack_trap <= stack_err; // [RL27]
        end
    end

    // saturating count of trap cycles
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trap_count <= 16'h0000;
        end else if (stack_err && (trap_count != 16'hFFFF)) begin
            trap_count <= trap_count + 16'h0001;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb_core @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_push_req;
        i_req.valid && (i_req.mode == AGSC_PUSH);
    endsequence
    sequence s_sp_push_over;
        s_push_req ##0 ((i_req.ptr_sel == AGSC_SP_REG) && (i_req.ptr_val > stack_limit));
    endsequence

    property p_limit_read_even;
        (bus_done && i_avs_read && (i_avs_address == AGSC_OFS_STACK_LIMIT)) |-> !o_avs_readdata[0];
    endproperty
    a_limit_read_even: assert property (p_limit_read_even) else $error("limit read odd"); // [RL2]
    property p_push_over_traps;
        s_sp_push_over |=> o_stack_trap;
    endproperty
    a_push_over_traps: assert property (p_push_over_traps) else $error("push above limit no trap"); // [RL5]
    property p_floor_traps;
        (i_req.valid && (i_req.mode == AGSC_POP) && (i_req.ptr_sel == AGSC_SP_REG)
            && (i_req.ptr_val >= AGSC_WORD_STEP) && (i_req.ptr_val < (AGSC_SFR_TOP + AGSC_WORD_STEP))) |=> o_stack_trap;
    endproperty
    a_floor_traps: assert property (p_floor_traps) else $error("pop below floor no trap"); // [RL6]
    property p_push_steps_up;
        s_push_req ##0 !ring_hit |=> (o_rsp.ptr_next == $past(i_req.ptr_val) + AGSC_WORD_STEP);
    endproperty
    a_push_steps_up: assert property (p_push_steps_up) else $error("push step wrong"); // [RL24]
    property p_pre_mod_first;
        (i_req.valid && (i_req.mode == AGSC_PRE_MOD) && !ring_hit)
            |=> (o_rsp.addr == $past(i_req.ptr_val) + $past(i_req.modifier));
    endproperty
    a_pre_mod_first: assert property (p_pre_mod_first) else $error("pre modify address wrong"); // [RL11]
    property p_indexed_sum;
        (i_req.valid && (i_req.mode == AGSC_REG_INDEXED) && !ring_hit)
            |=> (o_rsp.addr == $past(i_req.ptr_val) + $past(i_req.base_val));
    endproperty
    a_indexed_sum: assert property (p_indexed_sum) else $error("indexed address wrong"); // [RL12]
    property p_x_ptr_space;
        (i_req.valid && (i_req.cls == AGSC_CLS_MAC) && is_x_ptr(i_req.ptr_sel)) |=> !o_rsp.in_y_space;
    endproperty
    a_x_ptr_space: assert property (p_x_ptr_space) else $error("x pointer sent to y"); // [RL15]
    property p_y_ring_even;
        (i_req.valid && y_ring_hit) |=> !o_rsp.addr[0];
    endproperty
    a_y_ring_even: assert property (p_y_ring_even) else $error("y ring address odd"); // [RL23]
endmodule : agsc_core
`default_nettype wire

// [agsc_pkg.sv]
/*
 * Package for the address generation and stack check block: register map, field layout,
 * addressing mode and operand structures.
 * Assumes a 16-bit data space and a 32-bit Avalon-MM register bus.
 */
package agsc_pkg;
    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam logic [4:0] AGSC_OFS_STACK_LIMIT = 5'h00;
    localparam logic [4:0] AGSC_OFS_X_RING_START = 5'h04;
    localparam logic [4:0] AGSC_OFS_X_RING_END = 5'h08;
    localparam logic [4:0] AGSC_OFS_Y_RING_START = 5'h0C;
    localparam logic [4:0] AGSC_OFS_Y_RING_END = 5'h10;
    localparam logic [4:0] AGSC_OFS_RING_CONTROL = 5'h14;
    localparam logic [4:0] AGSC_OFS_STATUS = 5'h18;
    localparam logic [31:0] AGSC_UNMAPPED_READ = 32'h0000_0000;

    // ************************************************
    // fields and constants
    // ************************************************
    localparam int AGSC_X_ENABLE_BIT = 15;
    localparam int AGSC_Y_ENABLE_BIT = 14;
    localparam int AGSC_X_SEL_LSB = 0;
    localparam int AGSC_Y_SEL_LSB = 4;
    localparam logic [3:0] AGSC_SEL_OFF = 4'hF;
    localparam logic [15:0] AGSC_RING_CONTROL_RESET = 16'h00FF;
    localparam logic [15:0] AGSC_SFR_TOP = 16'h0800;
    localparam logic [15:0] AGSC_WORD_STEP = 16'h0002;
    localparam logic [16:0] AGSC_RING_MAX_BYTES = 17'h10000;
    localparam logic [3:0] AGSC_SP_REG = 4'hF;
    localparam logic [3:0] AGSC_DEFAULT_WORK_REG = 4'h0;
    localparam int AGSC_FILE_ADDR_W = 13;
    localparam int AGSC_SHORT_LIT_W = 5;
    localparam int AGSC_BRANCH_LIT_W = 16;
    localparam int AGSC_DISABLE_LIT_W = 14;
    localparam logic [3:0] AGSC_X_PTR_A = 4'h8;
    localparam logic [3:0] AGSC_X_PTR_B = 4'h9;
    localparam logic [3:0] AGSC_Y_PTR_A = 4'hA;
    localparam logic [3:0] AGSC_Y_PTR_B = 4'hB;

    // ************************************************
    // types
    // ************************************************
    typedef enum logic [3:0] {
        AGSC_FILE_DIRECT,
        AGSC_REG_DIRECT,
        AGSC_INDIRECT,
        AGSC_POST_MOD,
        AGSC_PRE_MOD,
        AGSC_REG_INDEXED,
        AGSC_LIT_OFFSET,
        AGSC_LITERAL,
        AGSC_PUSH,
        AGSC_POP
    } agsc_mode_e;

    typedef enum logic [1:0] {
        AGSC_CLS_MCU,
        AGSC_CLS_MOVE,
        AGSC_CLS_MAC,
        AGSC_CLS_OTHER
    } agsc_class_e;

    typedef struct packed {
        logic valid;
        agsc_class_e cls;
        agsc_mode_e mode;
        logic exc_push;
        logic [3:0] ptr_sel;
        logic [15:0] ptr_val;
        logic [15:0] base_val;
        logic [15:0] modifier;
        logic [12:0] file_addr;
        logic [15:0] literal;
        logic [7:0] status_low_byte;
    } agsc_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] ptr_next;
        logic ptr_write;
        logic in_y_space;
        logic [15:0] literal;
        logic [23:0] push_word;
        logic stack_error;
        logic fault;
    } agsc_rsp_s;
endpackage : agsc_pkg

// [agsc_decode_model.sv]
/*
 * Decode stage stand-in: hands one address request to the block and collects the answer.
 * Assumes the answer and trap show while the request is held, within a few clock edges.
 */
`timescale 1ns/1ps
`default_nettype none
module agsc_decode_model
    import agsc_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // request and answer
    output agsc_req_s o_req,
    input wire agsc_rsp_s i_rsp,
    input wire logic i_stack_trap
);
    agsc_rsp_s last_rsp;
    logic last_trap;
    logic got;
    agsc_class_e cls_sel = AGSC_CLS_MOVE;
    logic [3:0] reg_sel = 4'h2;
    initial o_req = '0;
    // prefetch pointers stay inside their own data space
    task automatic issue(input agsc_mode_e mode, input logic [15:0] ptr, base, modv, lit, input logic exc);
        agsc_req_s r;
        int n;
        r = '0;
        r.valid = 1'b1;
        r.cls = cls_sel;
        r.mode = mode;
        r.exc_push = exc;
        r.ptr_sel = (mode == AGSC_PUSH || mode == AGSC_POP) ? AGSC_SP_REG : reg_sel;
        r.ptr_val = ptr;
        r.base_val = base;
        r.modifier = modv;
        r.file_addr = lit[12:0];
        r.literal = lit;
        r.status_low_byte = 8'hA5;
        @(posedge i_sys_clk);
        o_req <= r;
        got = 1'b0;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
            got = (i_rsp.valid === 1'b1);
        end while (!got && n < 8);
        last_rsp = i_rsp;
        last_trap = i_stack_trap;
        // released lines show no stale value
        r = ~r;
        r.valid = 1'b0;
        o_req <= r;
    endtask : issue
endmodule : agsc_decode_model
`default_nettype wire

// [address_gen_stack_check_bench.sv]
/*
 * Self-checking bench for the address generation and stack check block.
 * Assumes the register bus answers after waitrequest drops and the decode model above.
 */
`timescale 1ns/1ps
`default_nettype none
module address_gen_stack_check_bench;
    import agsc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [4:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    agsc_req_s req;
    agsc_rsp_s rsp;
    logic trap;
    int bad_count = 0;
    int n_compared = 0;
    logic [31:0] q;
    agsc_core i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(address), .i_avs_read(read),
        .i_avs_write(write), .i_avs_writedata(writedata), .i_avs_byteenable(4'hF), .o_avs_readdata(readdata),
        .o_avs_waitrequest(waitrequest), .i_req(req), .o_rsp(rsp), .o_stack_trap(trap));
    agsc_decode_model m (.i_sys_clk(i_sys_clk), .o_req(req), .i_rsp(rsp), .i_stack_trap(trap));
    initial forever #2 i_sys_clk = ~i_sys_clk;
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge i_sys_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 16);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 16) begin
            check("waitrequest", 0, 1);
            summarize();
        end
    endtask : bus
    task automatic op(input string what, input agsc_mode_e md, input logic [15:0] p, b, mv, l, ea, input logic tr);
        m.issue(md, p, b, mv, l, 1'b0);
        check({what, " valid"}, m.got, 1);
        check({what, " addr"}, m.last_rsp.addr, ea);
        check({what, " trap"}, m.last_trap, tr);
        check({what, " error"}, m.last_rsp.stack_error, tr);
    endtask : op
    task automatic t_regs;
        logic [4:0] ofs [4] = '{AGSC_OFS_X_RING_START, AGSC_OFS_X_RING_END, AGSC_OFS_Y_RING_START, AGSC_OFS_Y_RING_END};
        foreach (ofs[i]) begin
            bus(1, ofs[i], 32'h0000_1230 + i * 2, q);
            bus(0, ofs[i], '0, q);
            check("ring bound", q[15:0], 16'h1230 + i * 2);
        end
        bus(1, AGSC_OFS_STACK_LIMIT, 32'h0000_17FF, q);
        bus(0, AGSC_OFS_STACK_LIMIT, '0, q);
        check("limit", q[15:0], 16'h17FE);
        bus(0, 5'h1C, '0, q);
        check("unmapped", q, AGSC_UNMAPPED_READ);
        $display("test regs done");
    endtask : t_regs
    task automatic t_stack;
        repeat (3) @(posedge i_sys_clk); // no stack access right after limit write
        op("push at limit", AGSC_PUSH, 16'h17FE, 0, 0, 0, 16'h17FE, 0);
        check("push next", m.last_rsp.ptr_next, 16'h1800);
        op("push past limit", AGSC_PUSH, 16'h1800, 0, 0, 0, 16'h1800, 1);
        op("pop low ok", AGSC_POP, 16'h0802, 0, 0, 0, 16'h0800, 0);
        op("pop under", AGSC_POP, 16'h0800, 0, 0, 0, 16'h07FE, 1);
        m.issue(AGSC_PUSH, 16'h1000, 0, 0, 16'h2468, 1'b1);
        check("exc push srl", m.last_rsp.push_word[23:16], 8'hA5);
        check("exc push pc", m.last_rsp.push_word[15:0], 16'h2468);
        $display("test stack done");
    endtask : t_stack
    task automatic t_modes;
        op("pre mod", AGSC_PRE_MOD, 16'h1000, 0, 16'hFFFE, 0, 16'h0FFE, 0);
        op("indexed", AGSC_REG_INDEXED, 16'h1000, 16'h0020, 0, 0, 16'h1020, 0);
        op("lit ofs", AGSC_LIT_OFFSET, 16'h1000, 0, 0, 16'h0006, 16'h1006, 0);
        op("file", AGSC_FILE_DIRECT, 0, 0, 0, 16'hFFFF, 16'h1FFF, 0);
        $display("test modes done");
    endtask : t_modes
    task automatic t_mac;
        bus(1, AGSC_OFS_RING_CONTROL, 32'h0000_80F2, q);
        op("ring wrap", AGSC_POST_MOD, 16'h1232, 0, 16'h0002, 0, 16'h1232, 0);
        check("ring wrap next", m.last_rsp.ptr_next, 16'h1230);
        op("ring jump", AGSC_POST_MOD, 16'h1230, 0, 16'h0006, 0, 16'h1230, 0);
        check("ring jump next", m.last_rsp.ptr_next, 16'h1232);
        op("ring low", AGSC_PRE_MOD, 16'h1230, 0, 16'hFFFE, 0, 16'h1232, 0);
        bus(1, AGSC_OFS_RING_CONTROL, 32'h0000_00FF, q);
        m.cls_sel = AGSC_CLS_MAC;
        m.reg_sel = AGSC_Y_PTR_B;
        op("mac y idx", AGSC_REG_INDEXED, 16'h1000, 16'h0020, 0, 0, 16'h1020, 0);
        check("mac y space", m.last_rsp.in_y_space, 1);
        check("mac y fault", m.last_rsp.fault, 0);
        m.reg_sel = AGSC_Y_PTR_A;
        op("mac a idx", AGSC_REG_INDEXED, 16'h1000, 16'h0020, 0, 0, 16'h1020, 0);
        check("mac a fault", m.last_rsp.fault, 1);
        m.reg_sel = AGSC_X_PTR_A;
        op("mac x", AGSC_INDIRECT, 16'h1000, 0, 0, 0, 16'h1000, 0);
        check("mac x space", m.last_rsp.in_y_space, 0);
        m.cls_sel = AGSC_CLS_MCU;
        op("mcu lit", AGSC_LITERAL, 0, 0, 0, 16'h00FF, 0, 0);
        check("mcu lit value", m.last_rsp.literal, 16'h001F);
        m.cls_sel = AGSC_CLS_OTHER;
        m.reg_sel = 4'h0;
        op("branch", AGSC_LITERAL, 0, 0, 0, 16'hFFFE, 0, 0);
        check("branch lit", m.last_rsp.literal, 16'hFFFE);
        m.reg_sel = 4'h1;
        op("disable", AGSC_LITERAL, 0, 0, 0, 16'hFFFF, 0, 0);
        check("disable lit", m.last_rsp.literal, 16'h3FFF);
        m.cls_sel = AGSC_CLS_MOVE;
        m.reg_sel = 4'h2;
        bus(0, AGSC_OFS_STATUS, '0, q);
        check("trap count seen", q[15:0] != 16'h0000, 1);
        $display("test mac done");
    endtask : t_mac
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_stack();
        t_modes();
        t_mac();
        summarize();
    end
endmodule : address_gen_stack_check_bench
`default_nettype wire
